// ===== hw/master_trigger_link_control.sv
`timescale 1ns/1ps
// Overview of operation
// - Invert received bits when receive inversion set
// - Invert transmitted bits when transmit inversion set
// - Pattern selector picks PRBS7/15/23/31
// - Tester enable switches link to pattern mode
// - Receive checker runs while its start is set
// - Generator emits pattern while transmit start set
// - Injections flip one bit each, merged into one while generator stopped
// - Receive sample chosen among four phases
// - Count messages and errors, clear together
// - Loopback answers triggers with busy pair
// - Presence taken from remote enable sense
// - Bypass flag forces master present
// - Wait forever for front-end acknowledges
// - Restart returns state machine to idle
// - Eight-bit map forwards enabled trigger types
// - Masked trigger answered with busy pair
// - Map bits: spill, pedestal, laser, calib, cosmics, aux
// - Software requests run begin message
// - Software requests run finish message
// - Acknowledge run begin with busy pair
// - Acknowledge run finish with busy pair
module master_trigger_link_control
	import link_ctrl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] master_rx_samples,
	output logic master_tx_line,
	input wire logic remote_enable_sense,
	output logic master_present,
	output logic fe_trigger,
	output logic [2:0] fe_trigger_type,
	input wire logic fe_busy_ack,
	input wire logic fe_release_ack
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] rx_sync1;
		logic [3:0] rx_sync2;
		logic sense_sync1;
		logic sense_sync2;
		logic rx_invert;
		logic tx_invert;
		logic [1:0] pattern;
		logic bert_enable;
		logic bert_rx_run;
		logic bert_tx_run;
		logic [1:0] sample_sel;
		logic loopback;
		logic presence_bypass;
		logic [7:0] trigger_forward_map;
		logic inject;
		logic run_begin_pend;
		logic run_finish_pend;
		logic rx_active;
		logic [3:0] rx_cnt;
		logic [8:0] rx_shift;
		logic tx_busy;
		logic [3:0] tx_cnt;
		logic [9:0] tx_shift;
		logic tx_line;
		link_state_t state;
		logic auto_ack;
		logic fe_trigger;
		logic [2:0] fe_trigger_type;
		logic present;
		logic [31:0] rx_count;
		logic [31:0] rx_err_count;
		logic [31:0] tx_count;
		logic [31:0] bert_err_count;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} link_regs_t;

	link_regs_t r;
	link_regs_t next_r;
	logic rx_data;

	prbs_if pl();

	prbs_engine u_prbs (
		.aclk(aclk),
		.aresetn(aresetn),
		.link(pl.engine)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	// Clear and increment in one cycle leaves a count of one, so no event is lost
	function automatic logic [31:0] count_next(input logic [31:0] cnt, input logic clr, input logic inc);
		logic [31:0] base;
		base = clr ? 32'h00000000 : cnt;
		return base + {31'h00000000, inc};
	endfunction : count_next

	assign rx_data = r.rx_sync2[r.sample_sel] ^ r.rx_invert;
	assign pl.rx_bit = rx_data;
	assign pl.pattern = r.pattern;
	assign pl.tx_run = r.bert_enable & r.bert_tx_run;
	assign pl.rx_run = r.bert_enable & r.bert_rx_run;
	assign pl.inject = r.inject;

	always_comb
	begin
		logic [31:0] ctrl_word;
		logic [31:0] status_word;
		logic [31:0] wval;
		logic do_write;
		logic cmd_ok;
		logic cnt_clr;
		logic restart;
		logic rx_done;
		logic rx_err;
		logic msg_ok;
		logic [7:0] msg;
		logic tx_free;
		logic tx_load;
		logic [7:0] tx_msg;
		ctrl_word = 32'h00000000;
		ctrl_word[CTRL_RX_INV] = r.rx_invert;
		ctrl_word[CTRL_TX_INV] = r.tx_invert;
		ctrl_word[CTRL_PATTERN +: 2] = r.pattern;
		ctrl_word[CTRL_BERT_ENA] = r.bert_enable;
		ctrl_word[CTRL_BERT_RX] = r.bert_rx_run;
		ctrl_word[CTRL_BERT_TX] = r.bert_tx_run;
		ctrl_word[CTRL_SAMPLE_SEL +: 2] = r.sample_sel;
		ctrl_word[CTRL_LOOPBACK] = r.loopback;
		ctrl_word[CTRL_PRSNT_BYP] = r.presence_bypass;
		status_word = 32'h00000000;
		status_word[STAT_PRESENT] = r.present;
		status_word[STAT_SYNCED] = pl.rx_synced;
		status_word[STAT_TX_BUSY] = r.tx_busy;
		status_word[STAT_SENSE] = r.sense_sync2;
		status_word[STAT_STATE +: 3] = r.state;
		wval = 32'h00000000;
		do_write = 1'b0;
		cmd_ok = 1'b0;
		rx_done = 1'b0;
		rx_err = 1'b0;
		msg_ok = 1'b0;
		msg = 8'h00;
		tx_load = 1'b0;
		tx_msg = 8'h00;
		cnt_clr = 1'b0;
		restart = 1'b0;
		tx_free = 1'b0;
		next_r = r;
		next_r.inject = 1'b0;
		next_r.fe_trigger = 1'b0;

		// ----------------------------------------
		// Synchronisers and presence
		// ----------------------------------------
		next_r.rx_sync1 = master_rx_samples;
		next_r.rx_sync2 = r.rx_sync1;
		next_r.sense_sync1 = remote_enable_sense;
		next_r.sense_sync2 = r.sense_sync1;
		next_r.present = r.presence_bypass | r.sense_sync2;

		// ----------------------------------------
		// Register bus slave
		// ----------------------------------------
		if (r.awready && s_axi_awvalid)
		begin
			next_r.awready = 1'b0;
			next_r.aw_addr = s_axi_awaddr;
		end
		if (r.wready && s_axi_wvalid)
		begin
			next_r.wready = 1'b0;
			next_r.w_data = s_axi_wdata;
			next_r.w_strb = s_axi_wstrb;
		end
		if (!r.awready && !r.wready && !r.bvalid)
		begin
			do_write = 1'b1;
			next_r.bvalid = 1'b1;
			next_r.bresp = RESP_OKAY;
			unique case (r.aw_addr)
				ADDR_CTRL:
				begin
					wval = merge_bytes(ctrl_word, r.w_data, r.w_strb);
					next_r.rx_invert = wval[CTRL_RX_INV];
					next_r.tx_invert = wval[CTRL_TX_INV];
					next_r.pattern = wval[CTRL_PATTERN +: 2];
					next_r.bert_enable = wval[CTRL_BERT_ENA];
					next_r.bert_rx_run = wval[CTRL_BERT_RX];
					next_r.bert_tx_run = wval[CTRL_BERT_TX];
					next_r.sample_sel = wval[CTRL_SAMPLE_SEL +: 2];
					next_r.loopback = wval[CTRL_LOOPBACK];
					next_r.presence_bypass = wval[CTRL_PRSNT_BYP];
				end
				ADDR_MAP:
				begin
					wval = merge_bytes({24'h000000, r.trigger_forward_map}, r.w_data, r.w_strb);
					next_r.trigger_forward_map = wval[7:0];
				end
				ADDR_CMD: cmd_ok = r.w_strb[0];
				ADDR_STATUS, ADDR_RX_CNT, ADDR_RX_ERR, ADDR_TX_CNT, ADDR_BERT_ERR:;
				default: next_r.bresp = RESP_SLVERR;
			endcase
		end
		if (r.bvalid && s_axi_bready)
		begin
			next_r.bvalid = 1'b0;
			next_r.awready = 1'b1;
			next_r.wready = 1'b1;
		end
		if (r.arready && s_axi_arvalid)
		begin
			next_r.arready = 1'b0;
			next_r.rvalid = 1'b1;
			next_r.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CTRL: next_r.rdata = ctrl_word;
				ADDR_CMD: next_r.rdata = 32'h00000000;
				ADDR_MAP: next_r.rdata = {24'h000000, r.trigger_forward_map};
				ADDR_STATUS: next_r.rdata = status_word;
				ADDR_RX_CNT: next_r.rdata = r.rx_count;
				ADDR_RX_ERR: next_r.rdata = r.rx_err_count;
				ADDR_TX_CNT: next_r.rdata = r.tx_count;
				ADDR_BERT_ERR: next_r.rdata = r.bert_err_count;
				default:
				begin
					next_r.rdata = 32'h00000000;
					next_r.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (r.rvalid && s_axi_rready)
		begin
			next_r.rvalid = 1'b0;
			next_r.arready = 1'b1;
		end
		cnt_clr = do_write && cmd_ok && r.w_data[CMD_CNT_CLR];
		restart = do_write && cmd_ok && r.w_data[CMD_RESTART];
		next_r.inject = do_write && cmd_ok && r.w_data[CMD_INJECT];

		// ----------------------------------------
		// Message receiver
		// ----------------------------------------
		// In tester mode the line carries pattern bits, so framing is held off
		if (r.bert_enable)
		begin
			next_r.rx_active = 1'b0;
		end
		else if (!r.rx_active)
		begin
			if (rx_data)
			begin
				next_r.rx_active = 1'b1;
				next_r.rx_cnt = 4'h0;
			end
		end
		else
		begin
			next_r.rx_shift = {r.rx_shift[7:0], rx_data};
			next_r.rx_cnt = r.rx_cnt + 4'h1;
			if (r.rx_cnt == RX_LAST)
			begin
				next_r.rx_active = 1'b0;
				rx_done = r.present;
			end
		end
		msg = r.rx_shift[7:0];
		if (rx_done)
		begin
			rx_err = (^{msg, rx_data}) ||
				!(msg[7:4] == OP_TRIGGER || msg[7:4] == OP_RUN_BEGIN_MSG || msg[7:4] == OP_RUN_FINISH_MSG);
			msg_ok = !rx_err;
		end

		// ----------------------------------------
		// Interface state machine
		// ----------------------------------------
		tx_free = !r.tx_busy && !r.bert_enable;
		unique case (r.state)
			ST_IDLE:
			begin
				if (msg_ok)
				begin
					if (msg[7:4] != OP_TRIGGER)
					begin
						next_r.state = ST_SEND_SET;
						next_r.auto_ack = 1'b1;
					end
					else if (r.loopback || !r.trigger_forward_map[msg[2:0]])
					begin
						next_r.state = ST_SEND_SET;
						next_r.auto_ack = 1'b1;
					end
					else
					begin
						next_r.fe_trigger = 1'b1;
						next_r.fe_trigger_type = msg[2:0];
						next_r.state = ST_WAIT_FE_SET;
						next_r.auto_ack = 1'b0;
					end
				end
				else if (tx_free && r.run_begin_pend)
				begin
					tx_load = 1'b1;
					tx_msg = {OP_RUN_BEGIN_REQUEST_MSG, 4'h0};
					next_r.run_begin_pend = 1'b0;
				end
				else if (tx_free && r.run_finish_pend)
				begin
					tx_load = 1'b1;
					tx_msg = {OP_RUN_FINISH_REQUEST_MSG, 4'h0};
					next_r.run_finish_pend = 1'b0;
				end
			end
			ST_WAIT_FE_SET:
			begin
				if (fe_busy_ack)
				begin
					next_r.state = ST_SEND_SET;
				end
			end
			ST_SEND_SET:
			begin
				if (tx_free)
				begin
					tx_load = 1'b1;
					tx_msg = {OP_BUSY_SET, 4'h0};
					next_r.state = r.auto_ack ? ST_SEND_CLR : ST_WAIT_FE_CLR;
				end
			end
			ST_WAIT_FE_CLR:
			begin
				if (fe_release_ack)
				begin
					next_r.state = ST_SEND_CLR;
				end
			end
			ST_SEND_CLR:
			begin
				if (tx_free)
				begin
					tx_load = 1'b1;
					tx_msg = {OP_BUSY_CLR, 4'h0};
					next_r.state = ST_IDLE;
				end
			end
			default: next_r.state = ST_IDLE;
		endcase
		if (restart)
		begin
			next_r.state = ST_IDLE;
			next_r.auto_ack = 1'b0;
		end
		// A request written while an older one is sent stays pending
		if (do_write && cmd_ok && r.w_data[CMD_RUN_BEGIN])
		begin
			next_r.run_begin_pend = 1'b1;
		end
		if (do_write && cmd_ok && r.w_data[CMD_RUN_FINISH])
		begin
			next_r.run_finish_pend = 1'b1;
		end

		// ----------------------------------------
		// Message transmitter and line driver
		// ----------------------------------------
		if (tx_load)
		begin
			next_r.tx_busy = 1'b1;
			next_r.tx_cnt = 4'h0;
			next_r.tx_shift = {1'b1, tx_msg, ^tx_msg};
		end
		else if (r.tx_busy)
		begin
			next_r.tx_shift = {r.tx_shift[8:0], 1'b0};
			next_r.tx_cnt = r.tx_cnt + 4'h1;
			if (r.tx_cnt == TX_LAST)
			begin
				next_r.tx_busy = 1'b0;
			end
		end
		next_r.tx_line = (r.bert_enable ? pl.tx_bit : (r.tx_busy & r.tx_shift[9])) ^ r.tx_invert;

		// ----------------------------------------
		// Counters
		// ----------------------------------------
		next_r.rx_count = count_next(r.rx_count, cnt_clr, rx_done);
		next_r.rx_err_count = count_next(r.rx_err_count, cnt_clr, rx_err);
		next_r.tx_count = count_next(r.tx_count, cnt_clr, tx_load);
		next_r.bert_err_count = count_next(r.bert_err_count, cnt_clr, pl.rx_error);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r <= '0;
			r.trigger_forward_map <= MAP_RESET;
			r.state <= ST_IDLE;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bresp = r.bresp;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_arready = r.arready;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rvalid = r.rvalid;
	assign master_tx_line = r.tx_line;
	assign master_present = r.present;
	assign fe_trigger = r.fe_trigger;
	assign fe_trigger_type = r.fe_trigger_type;

endmodule : master_trigger_link_control

// ===== shared/link_ctrl_pkg.sv
package link_ctrl_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SAMPLE_STEP_PS = 2500;
	localparam int SAMPLES_PER_CLK = CLK_PERIOD_PS / SAMPLE_STEP_PS;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_MAP = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_RX_CNT = 8'h10;
	localparam logic [7:0] ADDR_RX_ERR = 8'h14;
	localparam logic [7:0] ADDR_TX_CNT = 8'h18;
	localparam logic [7:0] ADDR_BERT_ERR = 8'h1C;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_RX_INV = 0;
	localparam int CTRL_TX_INV = 1;
	localparam int CTRL_PATTERN = 2;
	localparam int CTRL_BERT_ENA = 4;
	localparam int CTRL_BERT_RX = 5;
	localparam int CTRL_BERT_TX = 6;
	localparam int CTRL_SAMPLE_SEL = 8;
	localparam int CTRL_LOOPBACK = 10;
	localparam int CTRL_PRSNT_BYP = 11;
	localparam int CMD_INJECT = 0;
	localparam int CMD_CNT_CLR = 1;
	localparam int CMD_RESTART = 2;
	localparam int CMD_RUN_BEGIN = 3;
	localparam int CMD_RUN_FINISH = 4;
	localparam int STAT_PRESENT = 0;
	localparam int STAT_SYNCED = 1;
	localparam int STAT_TX_BUSY = 2;
	localparam int STAT_SENSE = 3;
	localparam int STAT_STATE = 4;
	localparam logic [7:0] MAP_RESET = 8'hFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Message frame: start bit, 8 bits MSB first, even parity
	// ----------------------------------------
	localparam logic [3:0] RX_LAST = 4'h8;
	localparam logic [3:0] TX_LAST = 4'h9;
	localparam logic [3:0] OP_TRIGGER = 4'h1;
	localparam logic [3:0] OP_RUN_BEGIN_MSG = 4'h2;
	localparam logic [3:0] OP_RUN_FINISH_MSG = 4'h3;
	localparam logic [3:0] OP_BUSY_SET = 4'h8;
	localparam logic [3:0] OP_BUSY_CLR = 4'h9;
	localparam logic [3:0] OP_RUN_BEGIN_REQUEST_MSG = 4'hA;
	localparam logic [3:0] OP_RUN_FINISH_REQUEST_MSG = 4'hB;

	// ----------------------------------------
	// Pattern tester
	// ----------------------------------------
	localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;
	localparam logic [5:0] SYNC_GOOD_BITS = 6'h20;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT_FE_SET = 3'h1,
		ST_SEND_SET = 3'h3,
		ST_WAIT_FE_CLR = 3'h2,
		ST_SEND_CLR = 3'h6
	} link_state_t;

	function automatic logic prbs_feedback(input logic [30:0] s, input logic [1:0] sel);
		logic fb;
		fb = 1'b0;
		unique case (sel)
			2'h0: fb = s[6] ^ s[5];
			2'h1: fb = s[14] ^ s[13];
			2'h2: fb = s[22] ^ s[17];
			2'h3: fb = s[30] ^ s[27];
		endcase
		return fb;
	endfunction : prbs_feedback

endpackage : link_ctrl_pkg

// ===== shared/prbs_if.sv
`timescale 1ns/1ps
interface prbs_if;
	logic [1:0] pattern;
	logic tx_run;
	logic rx_run;
	logic inject;
	logic rx_bit;
	logic tx_bit;
	logic rx_error;
	logic rx_synced;
	modport engine(input pattern, input tx_run, input rx_run, input inject, input rx_bit,
		output tx_bit, output rx_error, output rx_synced);
	modport ctrl(output pattern, output tx_run, output rx_run, output inject, output rx_bit,
		input tx_bit, input rx_error, input rx_synced);
endinterface : prbs_if

// ===== hw/prbs_engine.sv
`timescale 1ns/1ps
module prbs_engine
	import link_ctrl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	prbs_if.engine link
);

	typedef struct packed {
		logic [30:0] gen;
		logic [30:0] chk;
		logic inject_pend;
		logic tx_bit;
		logic rx_error;
		logic [5:0] good_cnt;
		logic synced;
	} prbs_state_t;

	prbs_state_t r;
	prbs_state_t next_r;

	always_comb
	begin
		logic fb;
		fb = prbs_feedback(r.gen, link.pattern);
		next_r = r;
		next_r.rx_error = 1'b0;
		// ----------------------------------------
		// Generator
		// ----------------------------------------
		if (link.tx_run)
		begin
			next_r.gen = {r.gen[29:0], fb};
			next_r.tx_bit = fb ^ r.inject_pend;
			next_r.inject_pend = link.inject;
		end
		else
		begin
			next_r.tx_bit = 1'b0;
			next_r.inject_pend = r.inject_pend | link.inject;
		end
		// ----------------------------------------
		// Self-synchronising checker
		// ----------------------------------------
		// One line error shows as up to three mismatches, since it passes both taps
		if (link.rx_run)
		begin
			next_r.chk = {r.chk[29:0], link.rx_bit};
			if (prbs_feedback(r.chk, link.pattern) != link.rx_bit)
			begin
				next_r.good_cnt = 6'h00;
				next_r.rx_error = r.synced;
			end
			else if (r.good_cnt != SYNC_GOOD_BITS)
			begin
				next_r.good_cnt = r.good_cnt + 6'h01;
			end
			else
			begin
				next_r.synced = 1'b1;
			end
		end
		else
		begin
			next_r.good_cnt = 6'h00;
			next_r.synced = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r <= '0;
			r.gen <= PRBS_SEED;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign link.tx_bit = r.tx_bit;
	assign link.rx_error = r.rx_error;
	assign link.rx_synced = r.synced;

endmodule : prbs_engine

// ===== bench/link_monitor.sv
`timescale 1ns/1ps
module link_monitor(
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic remote_enable_sense,
	input logic master_present,
	input logic fe_trigger,
	input logic [2:0] fe_trigger_type
);
	// ----------------------------------------
	// Bus and link checks
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_WR_RESP:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after take");
	AST_B_HOLD:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_W_BLOCK:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted before response");
	AST_RD_RESP:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not one cycle after take");
	AST_R_HOLD:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	AST_TRIG_WAIT:
		assert property (fe_trigger |=> !fe_trigger [*8])
		else $error("second trigger while waiting for front end");
	AST_TYPE_HOLD:
		assert property ($changed(fe_trigger_type) |-> fe_trigger)
		else $error("trigger type moved without a trigger");
	AST_PRESENT:
		assert property (($past(aresetn) && remote_enable_sense) [*3] |=> master_present)
		else $error("sensed master not reported present");
endmodule : link_monitor

bind master_trigger_link_control link_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .remote_enable_sense, .master_present, .fe_trigger, .fe_trigger_type);

// ===== bench/master_model.sv
`timescale 1ns/1ps
module master_model
	import link_ctrl_pkg::*;
(
	input logic aclk,
	input logic tx_line,
	input logic [11:0] cfg,
	input logic quiet,
	output logic [3:0] samples,
	output logic got,
	output logic [8:0] word
);
	logic line = 1'h0;
	logic [8:0] sh;
	int n = 0;

	// ----------------------------------------
	// Line drive and decode
	// ----------------------------------------
	// Unselected phases carry the opposite level, so a wrong sample choice corrupts data
	assign samples = cfg[4] ? {4{tx_line}} : {4{~(line ^ cfg[0])}} ^ (4'h1 << cfg[9:8]);

	always @(posedge aclk)
	begin
		got <= 1'h0;
		if (quiet || cfg[4])
			n <= 0;
		else if (n != 0)
		begin
			sh <= {sh[7:0], tx_line ^ cfg[1]};
			n <= n - 1;
			if (n == 1)
			begin
				got <= 1'h1;
				word <= {sh[7:0], tx_line ^ cfg[1]};
			end
		end
		else if ((tx_line ^ cfg[1]) === 1'h1)
			n <= 9;
	end

	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, ^b};
		for (int i = 9; i >= 0; i--)
		begin
			@(posedge aclk);
			line <= f[i];
		end
		@(posedge aclk);
		line <= 1'h0;
	endtask : send

	// Emulator answers run requests
	always
	begin
		@(posedge aclk);
		if (got && word[8:1] == {OP_RUN_BEGIN_REQUEST_MSG, 4'h0})
			send({OP_RUN_BEGIN_MSG, 4'h0});
		if (got && word[8:1] == {OP_RUN_FINISH_REQUEST_MSG, 4'h0})
			send({OP_RUN_FINISH_MSG, 4'h0});
	end
endmodule : master_model

// ===== bench/master_trigger_link_control_bench.sv
`timescale 1ns/1ps
module master_trigger_link_control_bench;
	import link_ctrl_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, remote_enable_sense = 1'h1;
	logic fe_busy_ack = 1'h0, fe_release_ack = 1'h0, quiet = 1'h0, lpbk = 1'h0, acking = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, map;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, seed = 32'h48F794DE;
	logic [3:0] s_axi_wstrb = 4'hF, master_rx_samples;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, master_tx_line, got;
	logic master_present, fe_trigger;
	logic [2:0] fe_trigger_type;
	logic [8:0] word;
	logic [11:0] mcfg = 12'h0;
	logic [9:0] exp_q[$];
	int ack_cnt = 0, checks = 0, miscompares = 0;

	master_trigger_link_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_rx_samples,
		.master_tx_line, .remote_enable_sense, .master_present, .fe_trigger, .fe_trigger_type, .fe_busy_ack,
		.fe_release_ack);
	master_model model (.aclk, .tx_line(master_tx_line), .cfg(mcfg), .quiet, .samples(master_rx_samples), .got, .word);

	initial
	begin
		forever #4 aclk = ~aclk;
	end

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic guard(input logic ok);
		if (!ok)
		begin
			miscompares++;
			end_sim();
		end
	endtask : guard

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int t = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			t++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1 && t < 100);
		s_axi_bready <= 1'h0;
		guard(s_axi_bvalid === 1'h1);
		check(32'(s_axi_bresp), 32'(r));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
		int t = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			t++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1 && t < 100);
		s_axi_rready <= 1'h0;
		guard(s_axi_rvalid === 1'h1);
		v = s_axi_rdata;
		check(32'(s_axi_rresp), 32'(r));
		check(v & m, e);
	endtask : rd

	// Inversion changes glitch the idle line, so the model stops listening meanwhile
	task automatic setc(input logic [11:0] c);
		quiet <= 1'h1;
		wr(ADDR_CTRL, 32'(c), RESP_OKAY);
		mcfg <= c;
		repeat (30) @(posedge aclk);
		quiet <= 1'h0;
	endtask : setc

	task automatic exp_tx(input logic [7:0] b);
		exp_q.push_back({1'h0, b, ^b});
	endtask : exp_tx

	task automatic drain();
		for (int t = 0; t < 400 && exp_q.size() != 0; t++)
			@(posedge aclk);
		guard(exp_q.size() == 0);
		repeat (20) @(posedge aclk);
	endtask : drain

	task automatic trig(input logic [2:0] k);
		if (map[k] && !lpbk)
			exp_q.push_back({7'h40, k});
		exp_tx({OP_BUSY_SET, 4'h0});
		exp_tx({OP_BUSY_CLR, 4'h0});
		model.send({OP_TRIGGER, 1'h0, k});
		drain();
	endtask : trig

	// Front end acknowledges late
	always @(posedge aclk)
	begin
		ack_cnt <= (fe_trigger && acking) ? 1 : (ack_cnt != 0 && ack_cnt < 90) ? ack_cnt + 1 : 0;
		fe_busy_ack <= ack_cnt == 40;
		fe_release_ack <= ack_cnt == 80;
	end

	always @(posedge aclk)
	begin
		if (fe_trigger === 1'h1 || got === 1'h1)
			check(fe_trigger ? {22'h0, 7'h40, fe_trigger_type} : {23'h0, word},
				exp_q.size() != 0 ? 32'(exp_q.pop_front()) : ALL);
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		rd(ADDR_CTRL, ALL, 32'h0, RESP_OKAY);
		rd(ADDR_MAP, 32'hFF, 32'(MAP_RESET), RESP_OKAY);
		rd(8'h20, ALL, 32'h0, RESP_SLVERR);
		wr(8'h24, 32'h0, RESP_SLVERR);
		seed = lfsr(seed);
		map = {seed[7:2], 2'h1};
		wr(ADDR_MAP, 32'(map), RESP_OKAY);
		rd(ADDR_MAP, 32'hFF, 32'(map), RESP_OKAY);
		for (int k = 0; k < 8; k++)
			trig(3'(k));
		for (int p = 0; p < 4; p++)
		begin
			setc(12'(p << CTRL_SAMPLE_SEL) | 12'(p));
			trig(3'h0);
		end
		setc(12'h0);
		remote_enable_sense <= 1'h0;
		repeat (5) @(posedge aclk);
		rd(ADDR_STATUS, 32'h1, 32'h0, RESP_OKAY);
		model.send({OP_TRIGGER, 4'h0});
		repeat (120) @(posedge aclk);
		setc(12'(1 << CTRL_PRSNT_BYP));
		rd(ADDR_STATUS, 32'h1, 32'h1, RESP_OKAY);
		trig(3'h0);
		remote_enable_sense <= 1'h1;
		lpbk = 1'h1;
		setc(12'(1 << CTRL_LOOPBACK));
		trig(3'h0);
		lpbk = 1'h0;
		setc(12'h0);
		acking <= 1'h0;
		exp_q.push_back(10'h200);
		model.send({OP_TRIGGER, 4'h0});
		repeat (200) @(posedge aclk);
		rd(ADDR_STATUS, 32'h70, 32'h10, RESP_OKAY);
		wr(ADDR_CMD, 32'(1 << CMD_RESTART), RESP_OKAY);
		rd(ADDR_STATUS, 32'h70, 32'h0, RESP_OKAY);
		acking <= 1'h1;
		trig(3'h0);
		wr(ADDR_CMD, 32'(1 << CMD_CNT_CLR), RESP_OKAY);
		for (int i = 0; i < 2; i++)
		begin
			exp_tx({i ? OP_RUN_FINISH_REQUEST_MSG : OP_RUN_BEGIN_REQUEST_MSG, 4'h0});
			exp_tx({OP_BUSY_SET, 4'h0});
			exp_tx({OP_BUSY_CLR, 4'h0});
			wr(ADDR_CMD, 32'(1 << (i ? CMD_RUN_FINISH : CMD_RUN_BEGIN)), RESP_OKAY);
			drain();
			rd(ADDR_TX_CNT, ALL, 32'(3 * i + 3), RESP_OKAY);
			rd(ADDR_RX_CNT, ALL, 32'(i + 1), RESP_OKAY);
		end
		model.send(8'hF0);
		repeat (30) @(posedge aclk);
		rd(ADDR_RX_ERR, ALL, 32'h1, RESP_OKAY);
		wr(ADDR_CMD, 32'(1 << CMD_CNT_CLR), RESP_OKAY);
		for (int i = 0; i < 3; i++)
			rd(ADDR_RX_CNT + 8'(4 * i), ALL, 32'h0, RESP_OKAY);
		for (int p = 0; p < 4; p++)
		begin
			setc(12'h70 | 12'(p << CTRL_PATTERN));
			wr(ADDR_CMD, 32'(1 << CMD_CNT_CLR), RESP_OKAY);
			repeat (100) @(posedge aclk);
			rd(ADDR_STATUS, 32'h2, 32'h2, RESP_OKAY);
			rd(ADDR_BERT_ERR, ALL, 32'h0, RESP_OKAY);
			wr(ADDR_CMD, 32'(1 << CMD_INJECT), RESP_OKAY);
			repeat (60) @(posedge aclk);
			rd(ADDR_BERT_ERR, 32'h0, 32'h0, RESP_OKAY);
			check(32'(v != 0), 32'h1);
		end
		setc(12'h30);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge aclk);
			check(32'(master_tx_line), 32'h0);
		end
		end_sim();
	end
endmodule : master_trigger_link_control_bench
